// ==== ics_down_timer.sv ====
// one-shot down counter: busy for exactly load_val cycles after a load
`timescale 1ns/1ps
module ics_down_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy_q
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
    end
    else if (cnt_q != '0)
    begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= load ? (load_val != '0) : (cnt_q > W'(1));
    end
  end

endmodule : ics_down_timer

// ==== ics_init_config.sv ====
// init configuration registers with spi access, reset stretcher and cyclic sense timing
`timescale 1ns/1ps
module ics_init_config #(
  // longer counts scale from the shortest one, so one override shortens a whole set
  parameter int unsigned RST_1MS_CYC  = ics_pkg::ICS_RST_1MS_CYC,
  parameter int unsigned RST_5MS_CYC  =
    RST_1MS_CYC * ics_pkg::ICS_RST_5MS_US / ics_pkg::ICS_RST_1MS_US,
  parameter int unsigned RST_10MS_CYC =
    RST_1MS_CYC * ics_pkg::ICS_RST_10MS_US / ics_pkg::ICS_RST_1MS_US,
  parameter int unsigned RST_20MS_CYC =
    RST_1MS_CYC * ics_pkg::ICS_RST_20MS_US / ics_pkg::ICS_RST_1MS_US,
  parameter int unsigned CYC_200_CYC  = ics_pkg::ICS_CYC_200_CYC,
  parameter int unsigned CYC_400_CYC  =
    CYC_200_CYC * ics_pkg::ICS_CYC_400_US / ics_pkg::ICS_CYC_200_US,
  parameter int unsigned CYC_800_CYC  =
    CYC_200_CYC * ics_pkg::ICS_CYC_800_US / ics_pkg::ICS_CYC_200_US,
  parameter int unsigned CYC_1600_CYC =
    CYC_200_CYC * ics_pkg::ICS_CYC_1600_US / ics_pkg::ICS_CYC_200_US
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_cs_b,
  input  wire logic                 spi_mosi,
  output logic                      spi_miso_q,
  output logic                      spi_miso_oe_q,
  input  wire logic                 init_phase,
  input  wire logic                 supply_above_hi,
  input  wire logic                 supply_above_lo,
  input  wire logic                 cyclic_en,
  input  wire logic                 cyclic_start,
  output ics_pkg::ics_reg_cfg_t     reg_cfg_q,
  output ics_pkg::ics_wd_cfg_t      wd_cfg_q,
  output logic                      rst_out_b_q,
  output logic                      uv_irq_q,
  output logic                      aux_5v_sel_q,
  output logic                      io0_active_q,
  output logic                      io1_sample_q
);
  import ics_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage 1 is read only by stage 2
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       sck_d1_q;
  logic       cs_d1_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q  <= 5'h1f;
      sync2_q  <= 5'h1f;
      sck_d1_q <= 1'b1;
      cs_d1_q  <= 1'b1;
    end
    else
    begin
      sync1_q  <= {spi_sck, spi_cs_b, spi_mosi, supply_above_hi, supply_above_lo};
      sync2_q  <= sync1_q;
      sck_d1_q <= sync2_q[4];
      cs_d1_q  <= sync2_q[3];
    end
  end

  logic sck_s;
  logic cs_s;
  logic mosi_s;
  logic above_hi_s;
  logic above_lo_s;
  assign {sck_s, cs_s, mosi_s, above_hi_s, above_lo_s} = sync2_q;

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  assign sck_rise = sck_s & ~sck_d1_q & ~cs_s;
  assign sck_fall = ~sck_s & sck_d1_q & ~cs_s;
  assign cs_fall  = ~cs_s & cs_d1_q;
  assign cs_rise  = cs_s & ~cs_d1_q;

  ////////////////////////////////////////////////////////////////////////////
  // spi frame shifter
  logic [15:0] shift_q;
  logic [4:0]  bitcnt_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q  <= '0;
      bitcnt_q <= '0;
    end
    else if (cs_fall)
    begin
      bitcnt_q <= '0;
    end
    else if (sck_rise)
    begin
      shift_q  <= {shift_q[14:0], mosi_s};
      bitcnt_q <= (bitcnt_q == 5'h1f) ? bitcnt_q : bitcnt_q + 5'h01;
    end
  end

  // a frame counts only if exactly sixteen bits were clocked; parity is not checked
  logic       frame_done;
  logic [1:0] frame_op;
  logic [4:0] frame_addr;
  logic       wr_ok;
  assign frame_done = cs_rise && (bitcnt_q == 5'(ICS_FRAME_BITS));
  assign frame_op   = shift_q[ICS_OP_HI:ICS_OP_LO];
  assign frame_addr = shift_q[ICS_ADDR_HI:ICS_ADDR_LO];
  assign wr_ok      = frame_done && (frame_op == ICS_OP_WRITE) && init_phase;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_cfg_q <= ICS_REG_RST;
      wd_cfg_q  <= ICS_WD_RST;
    end
    else if (wr_ok)
    begin
      if (frame_addr == ICS_ADDR_REG)
      begin
        reg_cfg_q <= shift_q[7:0];
      end
      if (frame_addr == ICS_ADDR_WD)
      begin
        wd_cfg_q <= shift_q[7:0];
      end
    end
  end

  // read data for the next frame
  logic [7:0] rd_data_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_data_q <= '0;
    end
    else if (frame_done && (frame_op == ICS_OP_READ))
    begin
      case (frame_addr)
        ICS_ADDR_REG: rd_data_q <= reg_cfg_q;
        ICS_ADDR_WD:  rd_data_q <= wd_cfg_q;
        default:      rd_data_q <= '0;
      endcase
    end
  end

  logic [15:0] miso_sh_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      miso_sh_q     <= '0;
      spi_miso_q    <= 1'b0;
      spi_miso_oe_q <= 1'b0;
    end
    else
    begin
      spi_miso_oe_q <= ~cs_s;
      if (cs_fall)
      begin
        miso_sh_q  <= {rd_data_q, 8'h00} << 1;
        spi_miso_q <= rd_data_q[7];
      end
      else if (sck_fall)
      begin
        miso_sh_q  <= miso_sh_q << 1;
        spi_miso_q <= miso_sh_q[15];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // undervoltage reset and interrupt
  logic uv_reset_cond;
  always_comb
  begin
    case (reg_cfg_q.supply_uv_threshold_sel)
      ICS_UV_INT_LO: uv_reset_cond = ~above_lo_s;
      ICS_UV_LO:     uv_reset_cond = ~above_lo_s;
      default:       uv_reset_cond = ~above_hi_s;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uv_irq_q     <= 1'b0;
      aux_5v_sel_q <= 1'b0;
    end
    else
    begin
      uv_irq_q     <= (reg_cfg_q.supply_uv_threshold_sel == ICS_UV_INT_LO) & ~above_hi_s;
      aux_5v_sel_q <= reg_cfg_q.aux_regulator_voltage_sel;
    end
  end

  logic [ICS_CNT_W-1:0] rst_len;
  always_comb
  begin
    case (reg_cfg_q.reset_pulse_length_sel)
      2'h0:    rst_len = ICS_CNT_W'(RST_1MS_CYC);
      2'h1:    rst_len = ICS_CNT_W'(RST_5MS_CYC);
      2'h2:    rst_len = ICS_CNT_W'(RST_10MS_CYC);
      default: rst_len = ICS_CNT_W'(RST_20MS_CYC);
    endcase
  end

  ics_rst_state_t rst_st_q;
  logic           rst_load;
  logic           rst_busy;
  assign rst_load = (rst_st_q == ICS_RST_LOW) && !uv_reset_cond;

  ics_down_timer #(.W(ICS_CNT_W)) u_rst_timer (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .load     (rst_load),
    .load_val (rst_len),
    .busy_q   (rst_busy)
  );

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_st_q    <= ICS_RST_LOW;
      rst_out_b_q <= 1'b0;
    end
    else if (uv_reset_cond)
    begin
      rst_st_q    <= ICS_RST_LOW;
      rst_out_b_q <= 1'b0;
    end
    else
    begin
      case (rst_st_q)
        ICS_RST_LOW: rst_st_q <= ICS_RST_EXT;
        ICS_RST_EXT:
        begin
          if (!rst_busy)
          begin
            rst_st_q    <= ICS_RST_RUN;
            rst_out_b_q <= 1'b1;
          end
        end
        ICS_RST_RUN: rst_out_b_q <= 1'b1;
        default:     rst_st_q    <= ICS_RST_LOW;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cyclic sense: first I/O on-time and second I/O sampling window
  logic [ICS_CNT_W-1:0] cyc_len;
  always_comb
  begin
    case (reg_cfg_q.cyclic_on_sel)
      2'h0:    cyc_len = ICS_CNT_W'(CYC_200_CYC);
      2'h1:    cyc_len = ICS_CNT_W'(CYC_400_CYC);
      2'h2:    cyc_len = ICS_CNT_W'(CYC_800_CYC);
      default: cyc_len = ICS_CNT_W'(CYC_1600_CYC);
    endcase
  end

  logic cyc_load;
  logic cyc_busy;
  assign cyc_load = cyclic_en & cyclic_start & ~cyc_busy;

  ics_down_timer #(.W(ICS_CNT_W)) u_cyc_timer (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .load     (cyc_load),
    .load_val (cyc_len),
    .busy_q   (cyc_busy)
  );

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io0_active_q <= 1'b0;
      io1_sample_q <= 1'b0;
    end
    else
    begin
      io0_active_q <= cyc_busy;
      io1_sample_q <= cyclic_en & (~reg_cfg_q.io_sync | cyc_busy);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  cfg_write_gate_a: assert property (
    !init_phase |=> $stable(reg_cfg_q) && $stable(wd_cfg_q))
    else $error("init register changed outside initialization");
  reg_write_a: assert property (
    wr_ok && frame_addr == ICS_ADDR_REG |=> reg_cfg_q == $past(shift_q[7:0]))
    else $error("regulator register write lost");
  wd_write_a: assert property (
    wr_ok && frame_addr == ICS_ADDR_WD |=> wd_cfg_q == $past(shift_q[7:0]))
    else $error("watchdog register write lost");
  write_needs_init_a: assert property (
    $changed(reg_cfg_q) |-> $past(init_phase) && $past(frame_done))
    else $error("regulator register changed without an init write");
  uv_irq_code_a: assert property (
    uv_irq_q |-> $past(reg_cfg_q.supply_uv_threshold_sel) == ICS_UV_INT_LO)
    else $error("undervoltage interrupt with wrong threshold code");
  rst_low_uv_a: assert property (
    uv_reset_cond |=> !rst_out_b_q)
    else $error("reset released during undervoltage");
  rst_hold_a: assert property (
    $rose(rst_out_b_q) |-> $past(rst_st_q) == ICS_RST_EXT && !$past(rst_busy))
    else $error("reset released before stretch ended");
  aux_follow_a: assert property (
    ##1 aux_5v_sel_q == $past(reg_cfg_q.aux_regulator_voltage_sel))
    else $error("aux voltage select does not follow register");
  io1_sync_a: assert property (
    io1_sample_q && $past(reg_cfg_q.io_sync) |-> io0_active_q)
    else $error("second I/O sampled outside first I/O activation");
  io0_start_a: assert property (
    cyc_load && cyc_len != '0 |-> ##2 io0_active_q [*2])
    else $error("first I/O activation did not start");

  write_init_c: cover property (wr_ok && frame_addr == ICS_ADDR_REG);
  write_ignored_c: cover property (frame_done && frame_op == ICS_OP_WRITE && !init_phase);
  reset_release_c: cover property ($rose(rst_out_b_q));
  cyclic_sense_c: cover property ($rose(io0_active_q) && reg_cfg_q.io_sync);

endmodule : ics_init_config

// ==== ics_init_config_test.sv ====
// self-checking testbench of the init configuration registers
`timescale 1ns/1ps
module ics_init_config_test;
  import ics_pkg::*;

  logic                  clk_sys;
  logic                  rst_b;
  logic                  spi_sck;
  logic                  spi_cs_b;
  logic                  spi_mosi;
  logic                  spi_miso_q;
  logic                  spi_miso_oe_q;
  logic                  init_phase;
  logic                  supply_above_hi;
  logic                  supply_above_lo;
  logic                  cyclic_en;
  logic                  cyclic_start;
  ics_reg_cfg_t          reg_cfg_q;
  ics_wd_cfg_t           wd_cfg_q;
  logic                  rst_out_b_q;
  logic                  uv_irq_q;
  logic                  aux_5v_sel_q;
  logic                  io0_active_q;
  logic                  io1_sample_q;
  logic [7:0]            exp_reg;
  logic [7:0]            exp_wd;
  logic [15:0]           rd;
  int                    cnt;
  int                    fails;
  int                    total_checks;

  // shortened base counts; the longer settings scale from these
  localparam int unsigned RST_BASE = 4;
  localparam int unsigned CYC_BASE = 5;

  ics_init_config #(
    .RST_1MS_CYC  (RST_BASE),
    .CYC_200_CYC  (CYC_BASE)
  ) ics_init_config_i (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .spi_sck         (spi_sck),
    .spi_cs_b        (spi_cs_b),
    .spi_mosi        (spi_mosi),
    .spi_miso_q      (spi_miso_q),
    .spi_miso_oe_q   (spi_miso_oe_q),
    .init_phase      (init_phase),
    .supply_above_hi (supply_above_hi),
    .supply_above_lo (supply_above_lo),
    .cyclic_en       (cyclic_en),
    .cyclic_start    (cyclic_start),
    .reg_cfg_q       (reg_cfg_q),
    .wd_cfg_q        (wd_cfg_q),
    .rst_out_b_q     (rst_out_b_q),
    .uv_irq_q        (uv_irq_q),
    .aux_5v_sel_q    (aux_5v_sel_q),
    .io0_active_q    (io0_active_q),
    .io1_sample_q    (io1_sample_q)
  );

  ics_spi_host ics_spi_host_i (
    .clk_sys (clk_sys),
    .miso    (spi_miso_q),
    .miso_oe (spi_miso_oe_q),
    .sck     (spi_sck),
    .cs_b    (spi_cs_b),
    .mosi    (spi_mosi)
  );

  always #12.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  // expectations and checks
  function automatic logic rst_at_hi(input int c);
    return (c == 0) || (c == 3);
  endfunction : rst_at_hi

  function automatic int stretch_len(input int l);
    int unsigned us [4];
    us = '{ICS_RST_1MS_US, ICS_RST_5MS_US, ICS_RST_10MS_US, ICS_RST_20MS_US};
    return int'(RST_BASE * us[l] / ICS_RST_1MS_US);
  endfunction : stretch_len

  function automatic int on_len(input int k);
    int unsigned us [4];
    us = '{ICS_CYC_200_US, ICS_CYC_400_US, ICS_CYC_800_US, ICS_CYC_1600_US};
    return int'(CYC_BASE * us[k] / ICS_CYC_200_US);
  endfunction : on_len

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr(input logic [4:0] addr, input logic [7:0] d);
    ics_spi_host_i.xfer({ICS_OP_WRITE, addr, 1'b0, d}, 16, rd);
  endtask : wr

  task automatic chk_regs;
    @(negedge clk_sys);
    chk("reg_cfg", exp_reg, reg_cfg_q);
    chk("wd_cfg", exp_wd, wd_cfg_q);
    chk("aux_sel", exp_reg[2], aux_5v_sel_q);
  endtask : chk_regs

  task automatic rst_wait;
    cnt = 0;
    while (rst_out_b_q !== 1'b1 && cnt < 400)
    begin
      @(negedge clk_sys);
      cnt++;
    end
    chk("rst release", 1'b1, rst_out_b_q);
  endtask : rst_wait

  task automatic test_done;
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    init_phase = 1'b1;
    supply_above_hi = 1'b1;
    supply_above_lo = 1'b1;
    cyclic_en = 1'b0;
    cyclic_start = 1'b0;
    fails = 0;
    total_checks = 0;
    void'($urandom(61));
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    exp_reg = 8'h80;
    exp_wd = 8'h42;
    chk_regs();
    for (int n = 0; n < 4; n++)
    begin
      exp_reg = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
      exp_wd = (n == 0) ? 8'h00 : (n == 1) ? 8'hFF : 8'($urandom);
      wr(ICS_ADDR_REG, exp_reg);
      wr(ICS_ADDR_WD, exp_wd);
      chk_regs();
    end
    // read data comes back one frame late
    ics_spi_host_i.xfer({ICS_OP_READ, ICS_ADDR_REG, 9'h000}, 16, rd);
    ics_spi_host_i.xfer({ICS_OP_READ, 5'h1F, 9'h000}, 16, rd);
    chk("read reg", exp_reg, rd[15:8]);
    ics_spi_host_i.xfer({ICS_OP_READ, ICS_ADDR_WD, 9'h000}, 16, rd);
    chk("read unmapped", 8'h00, rd[15:8]);
    ics_spi_host_i.xfer({ICS_OP_READ, 5'h00, 9'h000}, 16, rd);
    chk("read wd", exp_wd, rd[15:8]);
    ics_spi_host_i.xfer({ICS_OP_WRITE, ICS_ADDR_REG, 1'b0, ~exp_reg}, 15, rd);
    ics_spi_host_i.xfer({ICS_OP_WRITE, 5'h07, 1'b0, 8'h5A}, 16, rd);
    chk_regs();
    for (int c = 0; c < 4; c++)
    begin
      exp_reg = {1'b1, 2'(c), 5'h00};
      wr(ICS_ADDR_REG, exp_reg);
      supply_above_hi <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("rst at hi drop", !rst_at_hi(c), rst_out_b_q);
      chk("irq at hi drop", c == 1, uv_irq_q);
      @(posedge clk_sys);
      supply_above_lo <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("rst at lo drop", 1'b0, rst_out_b_q);
      @(posedge clk_sys);
      supply_above_hi <= 1'b1;
      supply_above_lo <= 1'b1;
      rst_wait();
    end
    for (int l = 0; l < 4; l++)
    begin
      exp_reg = {3'b100, 2'(l), 3'b000};
      wr(ICS_ADDR_REG, exp_reg);
      supply_above_hi <= 1'b0;
      repeat (8) @(posedge clk_sys);
      supply_above_hi <= 1'b1;
      rst_wait();
      chk_rng("reset stretch", stretch_len(l) + 2, stretch_len(l) + 6, cnt);
    end
    @(posedge clk_sys);
    cyclic_en <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      exp_reg = {k[0], 4'h0, 1'b0, 2'(k)};
      wr(ICS_ADDR_REG, exp_reg);
      cyclic_start <= 1'b1;
      @(posedge clk_sys);
      cyclic_start <= 1'b0;
      cnt = 0;
      repeat (2) @(negedge clk_sys);
      while (io0_active_q === 1'b1 && cnt < 100)
      begin
        if (cnt == 1)
          chk("sample during on", 1'b1, io1_sample_q);
        cnt++;
        @(negedge clk_sys);
      end
      chk_rng("on time", on_len(k), on_len(k), cnt);
      repeat (3) @(negedge clk_sys);
      chk("sample after on", !k[0], io1_sample_q);
    end
    @(posedge clk_sys);
    cyclic_en <= 1'b0;
    init_phase <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("sample off", 1'b0, io1_sample_q);
    wr(ICS_ADDR_REG, ~exp_reg);
    wr(ICS_ADDR_WD, ~exp_wd);
    chk_regs();
    test_done();
  end
endmodule : ics_init_config_test

// ==== ics_pkg.sv ====
// package: constants, field layouts and types of the init configuration registers
// What this block does
// - init registers writable only during initialization
// - regulator register at 0_0101, reset 0x80
// - watchdog register at 0_0110, fields as listed
// - sync bit gates second I/O sampling
// - threshold code selects reset/interrupt levels
// - reset held 1/5/10/20 ms after recovery
// - aux bit selects 3.3 V or 5.0 V
// - first I/O on 200/400/800/1600 us
package ics_pkg;

  localparam int unsigned ICS_CLK_HZ      = 40_000_000;
  localparam int unsigned ICS_CYC_PER_US  = ICS_CLK_HZ / 1_000_000;
  localparam int unsigned ICS_CNT_W       = 20;

  // spi frame layout
  localparam int unsigned ICS_FRAME_BITS  = 16;
  localparam int unsigned ICS_OP_HI       = 15;
  localparam int unsigned ICS_OP_LO       = 14;
  localparam int unsigned ICS_ADDR_HI     = 13;
  localparam int unsigned ICS_ADDR_LO     = 9;
  localparam int unsigned ICS_PARITY_BIT  = 8;
  localparam logic [1:0]  ICS_OP_READ     = 2'h0;
  localparam logic [1:0]  ICS_OP_WRITE    = 2'h1;

  // register addresses and reset values
  localparam logic [4:0]  ICS_ADDR_REG    = 5'h05;
  localparam logic [4:0]  ICS_ADDR_WD     = 5'h06;
  localparam logic [7:0]  ICS_REG_RST     = 8'h80;
  localparam logic [7:0]  ICS_WD_RST      = 8'h42;

  // undervoltage threshold codes
  localparam logic [1:0]  ICS_UV_HI_A     = 2'h0;
  localparam logic [1:0]  ICS_UV_INT_LO   = 2'h1;
  localparam logic [1:0]  ICS_UV_LO       = 2'h2;

  // reset pulse lengths and cyclic on-times in microseconds
  localparam int unsigned ICS_RST_1MS_US  = 1000;
  localparam int unsigned ICS_RST_5MS_US  = 5000;
  localparam int unsigned ICS_RST_10MS_US = 10000;
  localparam int unsigned ICS_RST_20MS_US = 20000;
  localparam int unsigned ICS_CYC_200_US  = 200;
  localparam int unsigned ICS_CYC_400_US  = 400;
  localparam int unsigned ICS_CYC_800_US  = 800;
  localparam int unsigned ICS_CYC_1600_US = 1600;

  localparam int unsigned ICS_RST_1MS_CYC  = ICS_RST_1MS_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_RST_5MS_CYC  = ICS_RST_5MS_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_RST_10MS_CYC = ICS_RST_10MS_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_RST_20MS_CYC = ICS_RST_20MS_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_CYC_200_CYC  = ICS_CYC_200_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_CYC_400_CYC  = ICS_CYC_400_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_CYC_800_CYC  = ICS_CYC_800_US * ICS_CYC_PER_US;
  localparam int unsigned ICS_CYC_1600_CYC = ICS_CYC_1600_US * ICS_CYC_PER_US;

  typedef struct packed {
    logic       io_sync;
    logic [1:0] supply_uv_threshold_sel;
    logic [1:0] reset_pulse_length_sel;
    logic       aux_regulator_voltage_sel;
    logic [1:0] cyclic_on_sel;
  } ics_reg_cfg_t;

  typedef struct packed {
    logic       irq_read_deadline_en;
    logic       mcu_overcurrent_cfg;
    logic       overcurrent_timer_cfg;
    logic       safe_pin_second_reset;
    logic [1:0] refresh_method_sel;
    logic       refresh_window_sel;
    logic       crank_en;
  } ics_wd_cfg_t;

  typedef enum logic [1:0] {
    ICS_RST_LOW  = 2'b00,
    ICS_RST_EXT  = 2'b01,
    ICS_RST_RUN  = 2'b10
  } ics_rst_state_t;

endpackage : ics_pkg

// ==== ics_spi_host.sv ====
// behavioural spi master standing in for the host microcontroller
`timescale 1ns/1ps
module ics_spi_host (
  input  wire logic clk_sys,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      sck,
  output logic      cs_b,
  output logic      mosi
);
  import ics_pkg::*;

  initial
  begin
    sck  = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; miso taken at the end of each sck high phase
  task automatic xfer(input logic [15:0] f, input int nbits, output logic [15:0] rd);
    logic [15:0] w;
    w = f;
    w[ICS_PARITY_BIT] = 1'b0;
    rd = 16'h0000;
    @(posedge clk_sys);
    cs_b <= 1'b0;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      repeat (5) @(posedge clk_sys);
      mosi <= w[i];
      repeat (5) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd[i] = miso_oe ? miso : 1'bx;
      sck <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    cs_b <= 1'b1;
    // idle data line must not keep the last bit
    mosi <= ~w[16-nbits];
    repeat (6) @(posedge clk_sys);
  endtask : xfer
endmodule : ics_spi_host
